// ==== hdl/qei_top.v ====
`include "qei_defines.vh"

// How it works
// [R1] A 32-bit position count moves up or down from decoded quadrature phases.
// [R2] Optional mode reads phase A as count pulses and phase B as direction.
// [R3] Index event captures count to index register; strobe event to strobe one.
// [R4] Capture event: rising edge only, or rising forward and falling reverse.
// [R5] All four encoder inputs pass a programmable noise filter.
// [R6] Filtering, decoding and counting all run on the peripheral clock.
// [R7] Counts every phase edge; phase limit scales with clock, 13.25 MHz at 80.
// [R8] Index reset mode clears the count on each index pulse.
// [R9] Max-count mode resets the count against the maximum count register.
// [R10] Single-marker mode clears the count only on the first index pulse.
// [R11] A count error sets a status flag and the count error interrupt.
// [R12] 16-bit loop timer with count, period and prescale reloads on timeout.
// [R13] Every loop timer timeout raises its interrupt.
// [R14] Pulse interval timer times a span of up to 255 encoder pulses.
// [R15] Reading the count captures phase A and B levels for status.
// [R16] Index and strobe captures each raise their own interrupt.
// [R17] A leading B counts up on every edge; B leading counts down.
// [R18] Max-count mode wraps up past max to zero, down past zero to max.

module qei_top
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Encoder pins
  input wire phase_a_input,
  input wire phase_b_input,
  input wire index_marker_input,
  input wire strobe_input,
  // Interrupt
  output wire irq
);

  localparam [31:0] PHASE_LIMIT_KHZ =
    `QEI_REF_PHASE_KHZ * `QEI_PCLK_MHZ / `QEI_REF_CLK_MHZ;

  reg [15:0] ctrl;
  reg [31:0] count;
  reg [31:0] max_count_reg;
  reg [31:0] index_capture_reg;
  reg [31:0] strobe_capture_reg;
  reg [1:0] ab_snap;
  reg err_flag;
  reg dir_up;
  reg armed;
  reg [`QEI_INT_W-1:0] int_stat;
  reg [`QEI_INT_W-1:0] int_mask;
  reg [`QEI_LT_W-1:0] lt_period;
  reg [`QEI_LT_W-1:0] lt_scale;
  reg [`QEI_LT_W-1:0] lt_count;
  reg [`QEI_LT_W-1:0] lt_presc;
  reg [`QEI_EET_N_W-1:0] eet_n;
  reg [`QEI_EET_N_W-1:0] eet_pulses;
  reg [31:0] eet_run;
  reg [31:0] eet_time;
  reg pa_q;
  reg pb_q;
  reg z_q;
  reg s_q;

  wire [3:0] raw_in;
  wire [3:0] filt;
  wire pa;
  wire pb;
  wire pz;
  wire ps;

  assign raw_in = {strobe_input, index_marker_input,
                   phase_b_input, phase_a_input};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_filt
      qei_filter u_filt
      (
        .pclk(pclk),
        .presetn(presetn),
        .filt_len(ctrl[`QEI_CTRL_FILT_HI:`QEI_CTRL_FILT_LO]), // see [R5]
        .pin(raw_in[gi]),
        .level(filt[gi])
      );
    end
  endgenerate

  assign pa = filt[0];
  assign pb = filt[1];
  assign pz = filt[2];
  assign ps = filt[3];

  wire enable = ctrl[`QEI_CTRL_EN];
  wire fdir_mode = ctrl[`QEI_CTRL_FDIR];
  wire ldir_mode = ctrl[`QEI_CTRL_LDIR];
  wire [1:0] rmode = ctrl[`QEI_CTRL_RMODE_HI:`QEI_CTRL_RMODE_LO];

  // APB decode
  wire wr_en = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  reg mapped;

  always @*
  begin
    case (paddr)
      `QEI_CTRL_OFF, `QEI_COUNT_OFF, `QEI_MAXCNT_OFF, `QEI_ZCAP_OFF,
      `QEI_SCAP_OFF, `QEI_STATUS_OFF, `QEI_ISTAT_OFF, `QEI_IMASK_OFF,
      `QEI_LTPER_OFF, `QEI_LTSCALE_OFF, `QEI_LTCOUNT_OFF,
      `QEI_EETCTL_OFF, `QEI_EETTIME_OFF:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire wr_ok = wr_en & mapped;

  // Quadrature and frequency/direction decode
  wire a_chg = pa ^ pa_q;
  wire b_chg = pb ^ pb_q;
  reg step;
  reg step_up;
  reg step_err;

  always @*
  begin
    step = 1'b0;
    step_up = 1'b0;
    step_err = 1'b0;
    if (enable)
    begin
      if (fdir_mode)
      begin
        step = pa & ~pa_q; // see [R2]
        step_up = pb;
      end
      else if (a_chg & b_chg)
        step_err = 1'b1; // see [R11]
      else if (a_chg | b_chg)
      begin
        step = 1'b1; // see [R7]
        step_up = pa ^ pb_q; // see [R17]
      end
    end
  end

  // Capture events
  wire z_rise = pz & ~z_q;
  wire z_fall = ~pz & z_q;
  wire s_rise = ps & ~s_q;
  wire s_fall = ~ps & s_q;
  wire z_evt = enable &
    (ldir_mode ? (dir_up ? z_rise : z_fall) : z_rise); // see [R4]
  wire s_evt = enable & (ldir_mode ? (dir_up ? s_rise : s_fall) : s_rise);
  wire z_pulse = enable & z_rise;

  // Next count
  wire ctrl_wr = wr_ok & (paddr == `QEI_CTRL_OFF);
  wire count_wr = wr_ok & (paddr == `QEI_COUNT_OFF);
  reg [31:0] next_count;

  always @*
  begin
    next_count = count;
    if (step)
    begin
      if (step_up)
      begin
        if (rmode == `QEI_RM_MAX && count >= max_count_reg)
          next_count = 32'h00000000; // see [R18]
        else
          next_count = count + 32'h00000001; // see [R1]
      end
      else
      begin
        if (rmode == `QEI_RM_MAX && count == 32'h00000000)
          next_count = max_count_reg; // see [R9]
        else
          next_count = count - 32'h00000001; // see [R1]
      end
    end
    if (z_pulse && rmode == `QEI_RM_INDEX)
      next_count = 32'h00000000; // see [R8]
    if (z_pulse && rmode == `QEI_RM_SINGLE && armed)
      next_count = 32'h00000000; // see [R10]
    if (count_wr)
      next_count = pwdata;
  end

  // Counter, capture registers and edge history
  always @(posedge pclk or negedge presetn) // see [R6]
  begin
    if (!presetn)
    begin
      count <= 32'h00000000;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      z_q <= 1'b0;
      s_q <= 1'b0;
      dir_up <= 1'b1;
      armed <= 1'b0;
      index_capture_reg <= 32'h00000000;
      strobe_capture_reg <= 32'h00000000;
      ab_snap <= 2'h0;
      err_flag <= 1'b0;
    end
    else
    begin
      count <= next_count;
      pa_q <= pa;
      pb_q <= pb;
      z_q <= pz;
      s_q <= ps;
      if (step)
        dir_up <= step_up;
      if (ctrl_wr &&
          pwdata[`QEI_CTRL_RMODE_HI:`QEI_CTRL_RMODE_LO] == `QEI_RM_SINGLE &&
          rmode != `QEI_RM_SINGLE)
        armed <= 1'b1; // see [R10]
      else if (z_pulse)
        armed <= 1'b0;
      if (z_evt)
        index_capture_reg <= count; // see [R3]
      if (s_evt)
        strobe_capture_reg <= count; // see [R3]
      if (rd_acc && paddr == `QEI_COUNT_OFF)
        ab_snap <= {pb, pa}; // see [R15]
      if (step_err)
        err_flag <= 1'b1; // see [R11]
      else if (wr_ok && paddr == `QEI_STATUS_OFF && pwdata[2])
        err_flag <= 1'b0;
    end
  end

  // Loop timer
  wire lt_en = ctrl[`QEI_CTRL_LTEN];
  wire lt_tick = lt_en & (lt_presc >= lt_scale);
  wire lt_timeout = lt_tick & (lt_count == {`QEI_LT_W{1'b0}});

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lt_presc <= {`QEI_LT_W{1'b0}};
      lt_count <= {`QEI_LT_W{1'b0}};
    end
    else if (!lt_en)
    begin
      lt_presc <= {`QEI_LT_W{1'b0}};
      lt_count <= lt_period;
    end
    else
    begin
      if (lt_tick)
        lt_presc <= {`QEI_LT_W{1'b0}};
      else
        lt_presc <= lt_presc + 16'h0001;
      if (lt_timeout)
        lt_count <= lt_period; // see [R12]
      else if (lt_tick)
        lt_count <= lt_count - 16'h0001; // see [R12]
    end
  end

  // Pulse interval timer
  wire eet_on = enable & (eet_n != {`QEI_EET_N_W{1'b0}});
  wire eet_span = eet_on & step & (eet_pulses == eet_n - 8'h01);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eet_pulses <= {`QEI_EET_N_W{1'b0}};
      eet_run <= 32'h00000000;
      eet_time <= 32'h00000000;
    end
    else if (!eet_on)
    begin
      eet_pulses <= {`QEI_EET_N_W{1'b0}};
      eet_run <= 32'h00000000;
    end
    else
    begin
      if (eet_span)
      begin
        eet_time <= eet_run + 32'h00000001; // see [R14]
        eet_run <= 32'h00000000;
        eet_pulses <= {`QEI_EET_N_W{1'b0}};
      end
      else
      begin
        if (eet_run != 32'hffffffff)
          eet_run <= eet_run + 32'h00000001;
        if (step)
          eet_pulses <= eet_pulses + 8'h01;
      end
    end
  end

  // Interrupt status, set wins over write-one-to-clear
  wire [`QEI_INT_W-1:0] int_set;
  wire [`QEI_INT_W-1:0] int_clr;

  assign int_set[`QEI_INT_ZCAP] = z_evt; // see [R16]
  assign int_set[`QEI_INT_SCAP] = s_evt; // see [R16]
  assign int_set[`QEI_INT_ERR] = step_err; // see [R11]
  assign int_set[`QEI_INT_LT] = lt_timeout; // see [R13]
  assign int_set[`QEI_INT_EET] = eet_span;
  assign int_clr = (wr_ok && paddr == `QEI_ISTAT_OFF) ?
                   pwdata[`QEI_INT_W-1:0] : {`QEI_INT_W{1'b0}};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat <= {`QEI_INT_W{1'b0}};
    else
      int_stat <= (int_stat & ~int_clr) | int_set;
  end

  assign irq = |(int_stat & int_mask);

  // Register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `QEI_CTRL_RST;
      max_count_reg <= `QEI_MAXCNT_RST;
      int_mask <= {`QEI_INT_W{1'b0}};
      lt_period <= `QEI_LTPER_RST;
      lt_scale <= `QEI_LTSCALE_RST;
      eet_n <= `QEI_EETCTL_RST;
    end
    else if (wr_ok)
    begin
      case (paddr)
        `QEI_CTRL_OFF: ctrl <= pwdata[15:0];
        `QEI_MAXCNT_OFF: max_count_reg <= pwdata;
        `QEI_IMASK_OFF: int_mask <= pwdata[`QEI_INT_W-1:0];
        `QEI_LTPER_OFF: lt_period <= pwdata[`QEI_LT_W-1:0];
        `QEI_LTSCALE_OFF: lt_scale <= pwdata[`QEI_LT_W-1:0];
        `QEI_EETCTL_OFF: eet_n <= pwdata[`QEI_EET_N_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data, registered in the setup phase
  reg [31:0] rd_mux;

  always @*
  begin
    case (paddr)
      `QEI_CTRL_OFF: rd_mux = {16'h0000, ctrl};
      `QEI_COUNT_OFF: rd_mux = count;
      `QEI_MAXCNT_OFF: rd_mux = max_count_reg;
      `QEI_ZCAP_OFF: rd_mux = index_capture_reg;
      `QEI_SCAP_OFF: rd_mux = strobe_capture_reg;
      `QEI_STATUS_OFF: rd_mux = {27'h0000000, armed, err_flag,
                                 dir_up, ab_snap};
      `QEI_ISTAT_OFF: rd_mux = {27'h0000000, int_stat};
      `QEI_IMASK_OFF: rd_mux = {27'h0000000, int_mask};
      `QEI_LTPER_OFF: rd_mux = {16'h0000, lt_period};
      `QEI_LTSCALE_OFF: rd_mux = {16'h0000, lt_scale};
      `QEI_LTCOUNT_OFF: rd_mux = {16'h0000, lt_count};
      `QEI_EETCTL_OFF: rd_mux = {24'h000000, eet_n};
      `QEI_EETTIME_OFF: rd_mux = eet_time;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
      prdata <= rd_mux;
  end

endmodule

// ==== shared/qei_defines.vh ====
`ifndef QEI_DEFINES_VH
`define QEI_DEFINES_VH

// Register byte offsets
`define QEI_CTRL_OFF 8'h00
`define QEI_COUNT_OFF 8'h04
`define QEI_MAXCNT_OFF 8'h08
`define QEI_ZCAP_OFF 8'h0c
`define QEI_SCAP_OFF 8'h10
`define QEI_STATUS_OFF 8'h14
`define QEI_ISTAT_OFF 8'h18
`define QEI_IMASK_OFF 8'h1c
`define QEI_LTPER_OFF 8'h20
`define QEI_LTSCALE_OFF 8'h24
`define QEI_LTCOUNT_OFF 8'h28
`define QEI_EETCTL_OFF 8'h2c
`define QEI_EETTIME_OFF 8'h30

// Control field positions
`define QEI_CTRL_EN 0
`define QEI_CTRL_FDIR 1
`define QEI_CTRL_LDIR 2
`define QEI_CTRL_RMODE_LO 3
`define QEI_CTRL_RMODE_HI 4
`define QEI_CTRL_LTEN 5
`define QEI_CTRL_FILT_LO 8
`define QEI_CTRL_FILT_HI 15

// Reset modes
`define QEI_RM_NONE 2'h0
`define QEI_RM_INDEX 2'h1
`define QEI_RM_MAX 2'h2
`define QEI_RM_SINGLE 2'h3

// Interrupt bit positions
`define QEI_INT_ZCAP 0
`define QEI_INT_SCAP 1
`define QEI_INT_ERR 2
`define QEI_INT_LT 3
`define QEI_INT_EET 4
`define QEI_INT_W 5

// Reset values
`define QEI_CTRL_RST 16'h0000
`define QEI_MAXCNT_RST 32'hffffffff
`define QEI_LTPER_RST 16'hffff
`define QEI_LTSCALE_RST 16'h0000
`define QEI_EETCTL_RST 8'h00

// Widths and timing
`define QEI_FILT_W 8
`define QEI_LT_W 16
`define QEI_EET_N_W 8
`define QEI_PCLK_MHZ 25
`define QEI_REF_CLK_MHZ 80
`define QEI_REF_PHASE_KHZ 13250

`endif

// ==== hdl/qei_filter.v ====
`include "qei_defines.vh"

module qei_filter
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Filter setting
  input wire [`QEI_FILT_W-1:0] filt_len,
  // Pin in, filtered level out
  input wire pin,
  output reg level
);

  reg sync1;
  reg sync2;
  reg [`QEI_FILT_W-1:0] stable_cnt;

  // Two-flop synchroniser, then level changes after filt_len+1 stable cycles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      stable_cnt <= {`QEI_FILT_W{1'b0}};
      level <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      if (sync2 == level)
        stable_cnt <= {`QEI_FILT_W{1'b0}};
      else if (stable_cnt >= filt_len)
      begin
        level <= sync2;
        stable_cnt <= {`QEI_FILT_W{1'b0}};
      end
      else
        stable_cnt <= stable_cnt + 8'h01;
    end
  end

endmodule

// ==== verif/qei_enc.sv ====
module qei_enc
(
  // Clock
  input wire logic clk,
  // Encoder lines
  output logic a,
  output logic b,
  output logic z,
  output logic s
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] p;
  initial
  begin
    p = 2'h0;
    {a, b, z, s} = 4'h0;
  end
  task automatic hold;
    repeat (8) @(posedge clk);
  endtask
  // Phase pattern 00,10,11,01: a leads going forward
  task automatic step(input bit fwd);
    p = fwd ? p + 2'h1 : p - 2'h1;
    a <= p[1] ^ p[0];
    b <= p[1];
    hold;
  endtask
  // Both lines move together, as from a broken wire
  task automatic jump;
    p = p + 2'h2;
    a <= p[1] ^ p[0];
    b <= p[1];
    hold;
  endtask
  task automatic glitch(input int n);
    a <= ~a;
    repeat (n) @(posedge clk);
    a <= ~a;
    hold;
  endtask
  // Count pulse on a, direction on b
  task automatic fd(input bit up);
    b <= up;
    hold;
    a <= 1'b1;
    hold;
    a <= 1'b0;
    b <= 1'b0;
    hold;
  endtask
  // Index line moved on its own, one edge per call
  task automatic edge_z(input bit lvl);
    z <= lvl;
    hold;
  endtask
  task automatic mark(input bit idx);
    z <= idx;
    s <= ~idx;
    hold;
    z <= 1'b0;
    s <= 1'b0;
    hold;
  endtask
endmodule

// ==== verif/qei_top_chk.sv ====
module qei_top_chk
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Interrupt
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_setup;
  logic wr_acc;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rd_setup <= 1'b0;
      wr_acc <= 1'b0;
    end
    else
    begin
      rd_setup <= psel && !penable && !pwrite;
      wr_acc <= psel && penable && pwrite;
    end
  zero_wait_a: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  unmapped_err_a: assert property
    (psel && penable && paddr > 8'h30 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property
    (psel && penable && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  unmapped_zero_a: assert property
    (psel && penable && !pwrite && paddr > 8'h30 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(prdata) |-> rd_setup)
    else $error("read data moved without a read");
  irq_reset_a: assert property (!$past(presetn) |-> !irq)
    else $error("interrupt high after reset");
  irq_clear_a: assert property ($fell(irq) |-> wr_acc)
    else $error("interrupt fell without a write");
endmodule
bind qei_top qei_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

// ==== verif/tb.sv ====
`include "qei_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, irq, pa, pb, pz, ps;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 pclk = ~pclk;
  qei_top i_qei_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_input(pa), .phase_b_input(pb), .index_marker_input(pz),
    .strobe_input(ps), .irq(irq));
  qei_enc i_qei_enc (.clk(pclk), .a(pa), .b(pb), .z(pz), .s(ps));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ad,
    input logic [31:0] wd, output logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, ad, wd, d);
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, ad, 32'h0, d);
    chk(d & m, e);
  endtask
  task automatic t_quad;
    rc(`QEI_MAXCNT_OFF, 32'hffffffff, 32'hffffffff);
    rc(8'h40, 32'hffffffff, 32'h0);
    wr(`QEI_CTRL_OFF, 32'h1);
    repeat (4) i_qei_enc.step(1'b1);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h4);
    repeat (3) i_qei_enc.step(1'b0);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h1);
    rc(`QEI_STATUS_OFF, 32'h3, 32'h1);
    wr(`QEI_CTRL_OFF, 32'h0401);
    i_qei_enc.glitch(2);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h1);
    rc(`QEI_STATUS_OFF, 32'h4, 32'h0);
  endtask
  task automatic t_fd;
    wr(`QEI_CTRL_OFF, 32'h1);
    i_qei_enc.step(1'b0);
    wr(`QEI_CTRL_OFF, 32'h3);
    i_qei_enc.fd(1'b1);
    i_qei_enc.fd(1'b1);
    i_qei_enc.fd(1'b0);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h1);
  endtask
  task automatic t_cap;
    wr(`QEI_CTRL_OFF, 32'h1);
    wr(`QEI_IMASK_OFF, 32'h1);
    i_qei_enc.mark(1'b1);
    rc(`QEI_ZCAP_OFF, 32'hffffffff, 32'h1);
    rc(`QEI_ISTAT_OFF, 32'h1f, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`QEI_ISTAT_OFF, 32'h1);
    chk({31'h0, irq}, 32'h0);
    i_qei_enc.mark(1'b0);
    rc(`QEI_SCAP_OFF, 32'hffffffff, 32'h1);
    rc(`QEI_ISTAT_OFF, 32'h1f, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(`QEI_CTRL_OFF, 32'h5);
    i_qei_enc.step(1'b0);
    i_qei_enc.edge_z(1'b1);
    rc(`QEI_ISTAT_OFF, 32'h1, 32'h0);
    i_qei_enc.step(1'b0);
    i_qei_enc.edge_z(1'b0);
    rc(`QEI_ZCAP_OFF, 32'hffffffff, 32'hffffffff);
    rc(`QEI_ISTAT_OFF, 32'h1, 32'h1);
  endtask
  task automatic t_reset;
    wr(`QEI_CTRL_OFF, 32'h09);
    i_qei_enc.mark(1'b1);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h0);
    wr(`QEI_CTRL_OFF, 32'h19);
    repeat (2) i_qei_enc.step(1'b1);
    i_qei_enc.mark(1'b1);
    i_qei_enc.step(1'b1);
    i_qei_enc.mark(1'b1);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h1);
    wr(`QEI_CTRL_OFF, 32'h11);
    wr(`QEI_MAXCNT_OFF, 32'h3);
    wr(`QEI_COUNT_OFF, 32'h0);
    repeat (4) i_qei_enc.step(1'b1);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h0);
    i_qei_enc.step(1'b0);
    rc(`QEI_COUNT_OFF, 32'hffffffff, 32'h3);
  endtask
  task automatic t_timers;
    wr(`QEI_ISTAT_OFF, 32'h1f);
    wr(`QEI_EETCTL_OFF, 32'h2);
    repeat (4) i_qei_enc.step(1'b1);
    rc(`QEI_ISTAT_OFF, 32'h10, 32'h10);
    rc(`QEI_EETTIME_OFF, 32'hffffffff, 32'h10);
    wr(`QEI_EETCTL_OFF, 32'h0);
    rc(`QEI_LTPER_OFF, 32'hffffffff, 32'hffff);
    wr(`QEI_LTPER_OFF, 32'h3);
    wr(`QEI_CTRL_OFF, 32'h21);
    repeat (2)
    begin
      wr(`QEI_ISTAT_OFF, 32'h1f);
      repeat (8) @(posedge pclk);
      rc(`QEI_ISTAT_OFF, 32'h8, 32'h8);
    end
    wr(`QEI_IMASK_OFF, 32'h8);
    chk({31'h0, irq}, 32'h1);
    wr(`QEI_CTRL_OFF, 32'h1);
    wr(`QEI_ISTAT_OFF, 32'h1f);
    wr(`QEI_IMASK_OFF, 32'h4);
    i_qei_enc.jump;
    rc(`QEI_STATUS_OFF, 32'h8, 32'h8);
    rc(`QEI_ISTAT_OFF, 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out;
    end
  end
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_quad;
    t_fd;
    t_cap;
    t_reset;
    t_timers;
    close_out;
  end
endmodule
